// [logic/dlpt_pkg.sv]
// Constants and table contents of the double-rate latency query table
package dlpt_pkg;

    // ==========================================================
    // Widths and synchroniser depth
    localparam int OFF_W = 6;
    localparam int BYTE_W = 8;
    localparam int SYNC_STAGES = 2;
    localparam int BIT_CNT_W = 3;
    localparam logic [BIT_CNT_W-1:0] BIT_LAST = 3'h7;
    localparam logic [OFF_W-1:0] OFF_MAX = 6'h3F;

    // ==========================================================
    // Latency code table layout (offsets in the combined query space)
    localparam logic [OFF_W-1:0] LCT_ID_OFF = 6'h00;
    localparam logic [OFF_W-1:0] LCT_LEN_OFF = 6'h01;
    localparam logic [OFF_W-1:0] LCT_ROWS_OFF = 6'h02;
    localparam logic [OFF_W-1:0] LCT_ROWLEN_OFF = 6'h03;
    localparam logic [OFF_W-1:0] LCT_HDR_OFF = 6'h04;
    localparam logic [OFF_W-1:0] LCT_DATA_OFF = 6'h0C;
    localparam logic [OFF_W-1:0] RSV_OFF = 6'h2C;
    localparam logic [OFF_W-1:0] RSV_LEN_OFF = 6'h2D;

    // ==========================================================
    // Table values
    localparam logic [BYTE_W-1:0] LCT_ID = 8'h9A;
    localparam logic [BYTE_W-1:0] LCT_LEN = 8'h2A;
    localparam logic [BYTE_W-1:0] LCT_ROWS = 8'h05;
    localparam logic [BYTE_W-1:0] LCT_ROWLEN = 8'h08;
    localparam logic [BYTE_W-1:0] HDR_FREQ_MARK = 8'h46;
    localparam logic [BYTE_W-1:0] HDR_CODE_MARK = 8'h43;
    // Opcodes: fast 3B/4B, dual 3B/4B, quad 3B/4B
    localparam logic [47:0] HDR_OPCODES = 48'h0D_0E_BD_BE_ED_EE;
    // Index 0 is the first data row
    localparam logic [3:0][BYTE_W-1:0] ROW_FREQ = {8'h42, 8'h42, 8'h42, 8'h32};
    localparam logic [3:0][BYTE_W-1:0] ROW_CODE = {8'h02, 8'h01, 8'h00, 8'h03};
    // Mode/latency pairs: fast, dual, quad
    localparam logic [3:0][47:0] ROW_CYC = {
        48'h04_05_02_06_01_08,
        48'h04_04_02_05_01_07,
        48'h04_02_02_04_01_06,
        48'h04_01_02_02_01_03
    };
    localparam logic [BYTE_W-1:0] RSV_ID = 8'hF0;
    localparam logic [BYTE_W-1:0] RSV_LEN = 8'h0F;
    localparam logic [BYTE_W-1:0] ERASED = 8'hFF;

    // ==========================================================
    // Serial output state machine
    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_load = 3'b010,
        st_shift = 3'b100
    } dlpt_state_t;

    // Fixed content lookup
    function automatic logic [BYTE_W-1:0] dlpt_table_byte(input logic [OFF_W-1:0] a);
        logic [OFF_W-1:0] rel;
        logic [1:0] row;
        logic [2:0] col;
        logic [47:0] cyc;
        logic [BYTE_W-1:0] b;
        rel = a - LCT_DATA_OFF;
        row = rel[4:3];
        col = rel[2:0];
        cyc = ROW_CYC[row];
        b = ERASED;
        if (a == LCT_ID_OFF) begin
            b = LCT_ID;
        end else if (a == LCT_LEN_OFF) begin
            b = LCT_LEN;
        end else if (a == LCT_ROWS_OFF) begin
            b = LCT_ROWS;
        end else if (a == LCT_ROWLEN_OFF) begin
            b = LCT_ROWLEN;
        end else if (a == LCT_HDR_OFF) begin
            b = HDR_FREQ_MARK;
        end else if (a == LCT_HDR_OFF + 6'h01) begin
            b = HDR_CODE_MARK;
        end else if (a < LCT_DATA_OFF) begin
            b = HDR_OPCODES[(5 - int'(a - LCT_HDR_OFF - 6'h02)) * 8 +: 8];
        end else if (a < RSV_OFF) begin
            if (col == 3'h0) begin
                b = ROW_FREQ[row];
            end else if (col == 3'h1) begin
                b = ROW_CODE[row];
            end else begin
                b = cyc[(5 - int'(col - 3'h2)) * 8 +: 8];
            end
        end else if (a == RSV_OFF) begin
            b = RSV_ID;
        end else if (a == RSV_LEN_OFF) begin
            b = RSV_LEN;
        end
        return b;
    endfunction : dlpt_table_byte

endpackage : dlpt_pkg

// [logic/dlpt_sync.sv]
// Two-flop level synchroniser for pin inputs
`timescale 1ns/10ps
module dlpt_sync #(
    parameter int STAGES = 2,
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic din,
    output logic dout
);
    logic [STAGES-1:0] chain;
    logic [STAGES-1:0] next_chain;

    always_comb begin
        next_chain = chain;
        if (clk_en) begin
            next_chain = {chain[STAGES-2:0], din};
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            chain <= {STAGES{RESET_VAL}};
        end else begin
            chain <= next_chain;
        end
    end

    assign dout = chain[STAGES-1];
endmodule : dlpt_sync

// [logic/dlpt_rom.sv]
// Read-only query table with registered read data
`timescale 1ns/10ps
module dlpt_rom
    import dlpt_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [dlpt_pkg::OFF_W-1:0] addr,
    output logic [dlpt_pkg::BYTE_W-1:0] rdata
);
    logic [BYTE_W-1:0] next_rdata;

    // No write path exists, so the content cannot be altered
    always_comb begin
        next_rdata = rdata;
        if (clk_en) begin
            next_rdata = dlpt_table_byte(addr);
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rdata <= ERASED;
        end else begin
            rdata <= next_rdata;
        end
    end
endmodule : dlpt_rom

// [logic/dlpt_table.sv]
// Serial query read of the double-rate latency table and reserved parameter
`timescale 1ns/10ps

module dlpt_table
    import dlpt_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic sck_pin,
    input wire logic cs_n_pin,
    input wire logic query_load,
    input wire logic [dlpt_pkg::OFF_W-1:0] query_offset,
    output logic query_dout,
    output logic query_doe,
    output logic query_byte_done,
    output logic query_busy
);
    import dlpt_pkg::*;

    // ==========================================================
    // Pin synchronisers and clock edge detection
    logic sck_sync;
    logic cs_n_sync;
    logic sck_prev;
    logic next_sck_prev;
    logic sck_fall;

    dlpt_sync #(.STAGES(SYNC_STAGES), .RESET_VAL(1'b0)) u_sync_sck (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .din(sck_pin),
        .dout(sck_sync)
    );

    // Deselected at reset so no byte starts on its own
    dlpt_sync #(.STAGES(SYNC_STAGES), .RESET_VAL(1'b1)) u_sync_cs (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .din(cs_n_pin),
        .dout(cs_n_sync)
    );

    always_comb begin
        next_sck_prev = clk_en ? sck_sync : sck_prev;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sck_prev <= 1'b0;
        end else begin
            sck_prev <= next_sck_prev;
        end
    end

    // Data changes on the falling edge so the host samples on the rising one
    assign sck_fall = sck_prev & ~sck_sync;

    // ==========================================================
    // Table storage
    logic [OFF_W-1:0] rd_off;
    logic [BYTE_W-1:0] rom_q;

    // All table bytes come from the fixed lookup
    dlpt_rom u_rom (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .addr(rd_off),
        .rdata(rom_q)
    );

    // ==========================================================
    // Byte sequencer and shifter
    dlpt_state_t state;
    dlpt_state_t next_state;
    logic [BYTE_W-1:0] shreg;
    logic [BYTE_W-1:0] next_shreg;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic [BIT_CNT_W-1:0] next_bit_cnt;
    logic [OFF_W-1:0] next_rd_off;
    logic next_doe;
    logic next_byte_done;
    logic next_busy;

    // Offset holds at the top so a long read keeps returning erased bytes
    function automatic logic [OFF_W-1:0] dlpt_step(input logic [OFF_W-1:0] o);
        return (o == OFF_MAX) ? o : o + 6'h01;
    endfunction : dlpt_step

    always_comb begin
        next_state = state;
        next_shreg = shreg;
        next_bit_cnt = bit_cnt;
        next_rd_off = rd_off;
        next_doe = query_doe;
        next_byte_done = 1'b0;
        next_busy = query_busy;
        if (clk_en) begin
            case (state)
                st_idle: begin
                    next_doe = 1'b0;
                    next_busy = 1'b0;
                    // Start offset only accepted between reads
                    if (query_load) begin
                        next_rd_off = query_offset;
                    end else if (!cs_n_sync) begin
                        next_state = st_load;
                        next_busy = 1'b1;
                    end
                end
                st_load: begin
                    // ROM output has settled on rd_off by now
                    next_shreg = rom_q;
                    next_bit_cnt = BIT_LAST;
                    next_rd_off = dlpt_step(rd_off);
                    next_doe = 1'b1;
                    next_state = st_shift;
                    if (cs_n_sync) begin
                        next_state = st_idle;
                        next_doe = 1'b0;
                    end
                end
                st_shift: begin
                    if (cs_n_sync) begin
                        next_state = st_idle;
                        next_doe = 1'b0;
                        next_busy = 1'b0;
                    end else if (sck_fall) begin
                        if (bit_cnt == '0) begin
                            // Next byte was prefetched during the last one
                            next_shreg = rom_q;
                            next_bit_cnt = BIT_LAST;
                            next_rd_off = dlpt_step(rd_off);
                            next_byte_done = 1'b1;
                        end else begin
                            next_shreg = {shreg[BYTE_W-2:0], 1'b0};
                            next_bit_cnt = bit_cnt - 3'h1;
                        end
                    end
                end
                default: begin
                    next_state = st_idle;
                    next_doe = 1'b0;
                    next_busy = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state <= st_idle;
            shreg <= '0;
            bit_cnt <= '0;
            rd_off <= LCT_ID_OFF;
            query_doe <= 1'b0;
            query_byte_done <= 1'b0;
            query_busy <= 1'b0;
        end else begin
            state <= next_state;
            shreg <= next_shreg;
            bit_cnt <= next_bit_cnt;
            rd_off <= next_rd_off;
            query_doe <= next_doe;
            query_byte_done <= next_byte_done;
            query_busy <= next_busy;
        end
    end

    // ==========================================================
    // Serial data output, MSB first
    logic next_dout;

    always_comb begin
        next_dout = query_dout;
        if (clk_en) begin
            next_dout = next_doe ? next_shreg[BYTE_W-1] : 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            query_dout <= 1'b0;
        end else begin
            query_dout <= next_dout;
        end
    end
endmodule : dlpt_table

// [sim/dlpt_checker.sv]
// Serial protocol assertions for the latency query table
`timescale 1ns/10ps
module dlpt_checker
    import dlpt_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic sck_pin,
    input wire logic cs_n_pin,
    input wire logic query_load,
    input wire logic [dlpt_pkg::OFF_W-1:0] query_offset,
    input wire logic query_dout,
    input wire logic query_doe,
    input wire logic query_byte_done,
    input wire logic query_busy
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    // ====
    // Sequences
    sequence s_desel;
        cs_n_pin [*5];
    endsequence
    sequence s_sel;
        !cs_n_pin [*7];
    endsequence
    sequence s_sck_high;
        (sck_pin && !cs_n_pin) [*4];
    endsequence
    // ====
    // Properties
    AST_DOE_IDLE: assert property (!query_doe |-> !query_dout) else $error("dout set while idle");
    AST_DOE_BUSY: assert property (query_doe |-> query_busy) else $error("doe without busy");
    AST_BD_PULSE: assert property (query_byte_done |=> !query_byte_done) else $error("byte_done too long");
    AST_BD_DOE: assert property (query_byte_done |-> query_doe) else $error("byte_done while idle");
    AST_BD_SCK: assert property (query_byte_done |-> !$past(sck_pin, 2)) else $error("byte_done w/o fall");
    AST_DESEL: assert property (s_desel |-> !query_busy && !query_doe) else $error("no release");
    AST_SEL: assert property (s_sel |-> query_doe && query_busy) else $error("select not answered");
    AST_DOUT_HOLD: assert property (s_sck_high |-> $stable(query_dout)) else $error("dout moved");
    // Select must have passed the sync stages before busy is bound to it
    AST_BUSY_HOLD: assert property ((!cs_n_pin [*3]) ##0 query_busy |=> query_busy) else $error("busy lost");
endmodule : dlpt_checker

bind dlpt_table dlpt_checker chk_u (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .sck_pin(sck_pin),
    .cs_n_pin(cs_n_pin), .query_load(query_load), .query_offset(query_offset), .query_dout(query_dout),
    .query_doe(query_doe), .query_byte_done(query_byte_done), .query_busy(query_busy));

// [sim/dlpt_host.sv]
// Host model that clocks query bytes out in mode 0
`timescale 1ns/10ps
module dlpt_host (
    input wire logic sys_clk,
    input wire logic query_dout,
    output logic sck_pin,
    output logic cs_n_pin
);
    initial begin
        sck_pin = 1'b0;
        cs_n_pin = 1'b1;
    end
    // ====
    // Frame: sample before the rise; wide phases cover the two-flop sync
    task automatic frame(input int n, input int part, output logic [7:0] q[$]);
        logic [7:0] b;
        q = {};
        @(negedge sys_clk);
        cs_n_pin = 1'b0;
        repeat (8) @(negedge sys_clk);
        for (int i = 0; i < n * 8 + part; i++) begin
            b = {b[6:0], query_dout};
            sck_pin = 1'b1;
            repeat (4) @(negedge sys_clk);
            sck_pin = 1'b0;
            repeat (6) @(negedge sys_clk);
            if (i % 8 == 7) q.push_back(b);
        end
        cs_n_pin = 1'b1;
        repeat (8) @(negedge sys_clk);
    endtask : frame

    // Lowest-latency row whose clock limit covers the host rate
    function automatic int pick_row(input logic [7:0] q[$], input int mhz);
        for (int r = 0; r < 4; r++) begin
            if (int'(q[12 + r * 8]) >= mhz) return r;
        end
        return -1;
    endfunction : pick_row
endmodule : dlpt_host

// [sim/dlpt_table_tb_top.sv]
// Testbench for the double-rate latency query table
`timescale 1ns/10ps
module dlpt_table_tb_top;
    import dlpt_pkg::*;
    logic sys_clk;
    logic reset;
    logic clk_en;
    logic sck_pin;
    logic cs_n_pin;
    logic query_load;
    logic [OFF_W-1:0] query_offset;
    logic query_dout;
    logic query_doe;
    logic query_byte_done;
    logic query_busy;
    int err_total;
    int tests_run;
    int bd_seen;
    int row_pick;
    logic [7:0] exp_mem [64];
    logic [7:0] got [$];

    dlpt_table dut_u (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .sck_pin(sck_pin),
        .cs_n_pin(cs_n_pin), .query_load(query_load), .query_offset(query_offset), .query_dout(query_dout),
        .query_doe(query_doe), .query_byte_done(query_byte_done), .query_busy(query_busy));
    dlpt_host host_u (.sys_clk(sys_clk), .query_dout(query_dout), .sck_pin(sck_pin), .cs_n_pin(cs_n_pin));

    // ====
    // Reference table
    task automatic build_model();
        int cyc [4][6] = '{'{4, 1, 2, 2, 1, 3}, '{4, 2, 2, 4, 1, 6}, '{4, 4, 2, 5, 1, 7}, '{4, 5, 2, 6, 1, 8}};
        int mhz [4] = '{50, 66, 66, 66};
        int code [4] = '{3, 0, 1, 2};
        logic [7:0] hdr [12] = '{8'h9A, 8'h2A, 8'h05, 8'h08, 8'h46, 8'h43,
            8'h0D, 8'h0E, 8'hBD, 8'hBE, 8'hED, 8'hEE};
        foreach (exp_mem[i]) exp_mem[i] = 8'hFF;
        foreach (hdr[i]) exp_mem[i] = hdr[i];
        for (int r = 0; r < 4; r++) begin
            exp_mem[12 + r * 8] = 8'(mhz[r]);
            exp_mem[13 + r * 8] = 8'(code[r]);
            for (int c = 0; c < 6; c++) exp_mem[14 + r * 8 + c] = 8'(cyc[r][c]);
        end
        exp_mem[1 + 8'h2A + 1] = 8'hF0;
        exp_mem[8'h2D] = 8'h0F;
    endtask : build_model

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic final_report();
        $display("Checks %0d, errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    // ====
    // One frame; poke loads a stray offset mid-frame, which must be ignored, then stalls clk_en a cycle
    task automatic read_at(input int off, input int n, input int part, input bit load, input bit poke);
        int o;
        int bd0;
        if (load) begin
            @(negedge sys_clk);
            query_offset = 6'(off);
            query_load = 1'b1;
            @(negedge sys_clk);
            query_load = 1'b0;
        end
        bd0 = bd_seen;
        fork
            host_u.frame(n, part, got);
            if (poke) begin
                repeat (40) @(negedge sys_clk);
                query_offset = 6'($urandom);
                query_load = 1'b1;
                @(negedge sys_clk);
                query_load = 1'b0;
                clk_en = 1'b0;
                @(negedge sys_clk);
                clk_en = 1'b1;
            end
        join
        check(8'(bd_seen - bd0), 8'(n), "byte count");
        foreach (got[i]) begin
            o = (off + i > 63) ? 63 : off + i;
            check(got[i], exp_mem[o], "table byte");
        end
    endtask : read_at

    always @(negedge sys_clk) begin
        if (query_byte_done === 1'b1) bd_seen++;
    end

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (60000) @(posedge sys_clk);
        err_total++;
        $display("Error at %0t: timeout", $time);
        final_report();
    end

    initial begin
        reset = 1'b1;
        clk_en = 1'b1;
        query_load = 1'b0;
        query_offset = 6'h00;
        err_total = 0;
        tests_run = 0;
        bd_seen = 0;
        build_model();
        void'($urandom(32'hA3184D7A));
        repeat (16) @(negedge sys_clk);
        reset = 1'b0;
        check(8'(query_busy), 8'h00, "busy after reset");
        read_at(0, 64, 0, 1, 1);
        // Host serial clock is ten system cycles, 25 MHz
        row_pick = host_u.pick_row(got, 25);
        check(8'(row_pick), 8'h00, "row for 25 MHz");
        check(got[13 + row_pick * 8], 8'h03, "code for 25 MHz");
        check(got[15 + row_pick * 8], 8'h01, "fast dummy for 25 MHz");
        row_pick = host_u.pick_row(got, 60);
        check(8'(row_pick), 8'h01, "row for 60 MHz");
        check(got[19 + row_pick * 8], 8'h06, "quad dummy for 60 MHz");
        read_at(8'h3C, 6, 0, 1, 0);
        read_at(1, 2, 5, 1, 0);
        read_at(4, 2, 0, 0, 0);
        repeat (6) read_at($urandom_range(0, 63), $urandom_range(1, 4), 0, 1, 0);
        final_report();
    end
endmodule : dlpt_table_tb_top
